// ---- logic/pllcs_pkg.sv ----
`default_nettype none
package pllcs_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [31:0] PLLCS_OFF_STATUS = 32'h0000_0000;
    localparam logic [31:0] PLLCS_OFF_MASK   = 32'h0000_0004;
    localparam logic [31:0] PLLCS_OFF_STATE  = 32'h0000_0008;

    // ----------------------------------------
    // Event bits of status and mask
    // ----------------------------------------
    localparam int          PLLCS_EV_W         = 3;
    localparam int          PLLCS_EV_LOCK_GAIN = 0;
    localparam int          PLLCS_EV_LOCK_LOSS = 1;
    localparam int          PLLCS_EV_CFG_CHG   = 2;
    localparam logic [2:0]  PLLCS_MASK_RST     = 3'h0;
    localparam logic [2:0]  PLLCS_STATUS_RST   = 3'h0;

    // ----------------------------------------
    // State register layout
    // ----------------------------------------
    localparam int          PLLCS_STATE_LOCK   = 16;
    localparam int          PLLCS_STATE_SINK   = 17;
    localparam int          PLLCS_STATE_SOURCE = 18;

    // ----------------------------------------
    // Select codes
    // ----------------------------------------
    localparam logic [1:0]  PLLCS_REF_IN1      = 2'h0;
    localparam logic [1:0]  PLLCS_REF_IN2      = 2'h1;
    localparam logic [1:0]  PLLCS_REF_IN3      = 2'h2;
    localparam logic [1:0]  PLLCS_REF_NONE     = 2'h3;
    localparam logic [2:0]  PLLCS_PRE_DIV1     = 3'h0;
    localparam logic [2:0]  PLLCS_PRE_OFF      = 3'h7;
    localparam logic [1:0]  PLLCS_OSC_EXT_DIV2 = 2'h0;
    localparam logic [1:0]  PLLCS_OSC_INT_622  = 2'h1;
    localparam logic [1:0]  PLLCS_OSC_INT_1244 = 2'h2;
    localparam logic [1:0]  PLLCS_OSC_EXT_DIV1 = 2'h3;

    // ----------------------------------------
    // Internal oscillator half periods, in hclk cycles
    // ----------------------------------------
    localparam logic [2:0]  PLLCS_INT_HALF_622  = 3'h2;
    localparam logic [2:0]  PLLCS_INT_HALF_1244 = 3'h1;

    // ----------------------------------------
    // Lock filter levels
    // ----------------------------------------
    localparam logic [7:0]  PLLCS_LOCK_ON  = 8'h10;
    localparam logic [7:0]  PLLCS_LOCK_OFF = 8'h40;
    localparam logic [7:0]  PLLCS_LOCK_MAX = 8'hFF;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] ref_code;
        logic [2:0] pre_code;
        logic [1:0] osc_code;
        logic [5:0] out_en;
    } pllcs_cfg_type;

    typedef struct packed {
        logic ref1;
        logic ref2;
        logic ref3;
        logic ext;
    } pllcs_clkin_type;

    localparam pllcs_cfg_type   PLLCS_CFG_RST   = pllcs_cfg_type'(13'h1FFF);
    localparam pllcs_clkin_type PLLCS_CLKIN_RST = pllcs_clkin_type'(4'h0);

endpackage : pllcs_pkg
`default_nettype wire

// ---- logic/pllcs_fb_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module pllcs_fb_div import pllcs_pkg::*; (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Master clock and divide code
    input  wire logic       master,
    input  wire logic [2:0] code,
    // Divided feedback
    output logic            fb
);
    logic       prev_r, prev_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic       fb_r, fb_nxt;

    always_comb begin
        prev_nxt = master;
        cnt_nxt  = (master && !prev_r) ? 6'(cnt_r + 6'h01) : cnt_r;
        if (code == PLLCS_PRE_OFF) begin
            fb_nxt = 1'b0;
        end else if (code == PLLCS_PRE_DIV1) begin
            fb_nxt = master;
        end else begin
            fb_nxt = cnt_r[3'(code - 3'h1)];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 1'b0;
            cnt_r  <= 6'h00;
            fb_r   <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            cnt_r  <= cnt_nxt;
            fb_r   <= fb_nxt;
        end
    end

    assign fb = fb_r;

    a_fb_off_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        code == PLLCS_PRE_OFF |=> !fb_r) else $error("feedback active with prescaler off");
    a_fb_div_one: assert property (@(posedge hclk) disable iff (!hresetn)
        code == PLLCS_PRE_DIV1 |=> fb_r == $past(master)) else $error("divide by one not followed");
endmodule : pllcs_fb_div
`default_nettype wire

// ---- logic/pllcs_out_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module pllcs_out_div import pllcs_pkg::*; (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Master clock and enables
    input  wire logic       master,
    input  wire logic [5:0] en,
    // Outputs: a, b, /2, /4, /8, /16
    output logic [5:0]      clk_out
);
    logic       prev_r, prev_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [5:0] clk_r, clk_nxt;

    sequence s_master_rise;
        master && !prev_r;
    endsequence

    always_comb begin
        prev_nxt = master;
        cnt_nxt  = (master && !prev_r) ? 4'(cnt_r + 4'h1) : cnt_r;
        // Disabled lanes drive a solid zero, never float
        clk_nxt  = {master, master, cnt_r[0], cnt_r[1], cnt_r[2], cnt_r[3]} & en;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 1'b0;
            cnt_r  <= 4'h0;
            clk_r  <= 6'h00;
        end else begin
            prev_r <= prev_nxt;
            cnt_r  <= cnt_nxt;
            clk_r  <= clk_nxt;
        end
    end

    assign clk_out = clk_r;

    a_out_off_low: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (clk_r & ~$past(en)) == 6'h00) else $error("disabled output not low");
    a_half_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        s_master_rise |=> cnt_r[0] != $past(cnt_r[0])) else $error("half rate lane missed a toggle");
endmodule : pllcs_out_div
`default_nettype wire

// ---- logic/pllcs_top.sv ----
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - With reference select at 11 no reference reaches the detector.
// - Prescale codes 000 to 110 divide the feedback by 1, 2, 4, 8, 16, 32 and 64.
// - Prescale code 111 gives no feedback to the detector.
// - Source 00 is external divided by 2, 01 internal at 622 rate, 10 internal at 1244 rate.
// - Source 11, the default, takes the external oscillator undivided.
// - Every select and enable pin reads as one until driven otherwise.
// - Each of the six outputs toggles when its enable is one and stops when it is zero.
// - A stopped output is driven at a steady zero, never released.
// - Two master outputs run at the master rate, the others at half, quarter, eighth and sixteenth.
// - The lock flag is low while locked and high while out of lock.
// - The raw lock output is the exclusive-or of reference and feedback, and the flag filters it.
// - The charge pump sinks to raise the oscillator frequency and sources to lower it.
module pllcs_top import pllcs_pkg::*; (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Clock pins
    input  wire logic        ref_clock_in_1,
    input  wire logic        ref_clock_in_2,
    input  wire logic        ref_clock_in_3,
    input  wire logic        ext_osc_in,
    // Select pins
    input  wire logic        ref_select_hi,
    input  wire logic        ref_select_lo,
    input  wire logic        prescale_select_b2,
    input  wire logic        prescale_select_b1,
    input  wire logic        prescale_select_b0,
    input  wire logic        osc_source_select_hi,
    input  wire logic        osc_source_select_lo,
    // Output enables
    input  wire logic        out_enable_master_a,
    input  wire logic        out_enable_master_b,
    input  wire logic        out_enable_div2,
    input  wire logic        out_enable_div4,
    input  wire logic        out_enable_div8,
    input  wire logic        out_enable_div16,
    // Clock outputs
    output logic             clk_out_master_a,
    output logic             clk_out_master_b,
    output logic             clk_out_half,
    output logic             clk_out_quarter,
    output logic             clk_out_eighth,
    output logic             clk_out_sixteenth,
    // Loop status
    output logic             lock_flag_n,
    output logic             lock_detect_raw,
    output logic             cp_sink,
    output logic             cp_source,
    output logic             irq
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    pllcs_cfg_type   cfg_pin;
    pllcs_clkin_type clk_pin;
    pllcs_cfg_type   cfg_s1_r, cfg_s2_r;
    pllcs_clkin_type clk_s1_r, clk_s2_r;

    assign cfg_pin = pllcs_cfg_type'({ref_select_hi, ref_select_lo,
                                      prescale_select_b2, prescale_select_b1, prescale_select_b0,
                                      osc_source_select_hi, osc_source_select_lo,
                                      out_enable_master_a, out_enable_master_b, out_enable_div2,
                                      out_enable_div4, out_enable_div8, out_enable_div16});
    assign clk_pin = pllcs_clkin_type'({ref_clock_in_1, ref_clock_in_2, ref_clock_in_3, ext_osc_in});

    // Select and enable stages load ones at reset so an idle board sees the pull-up defaults; clock stages load zeros
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_s1_r <= PLLCS_CFG_RST;
            cfg_s2_r <= PLLCS_CFG_RST;
            clk_s1_r <= PLLCS_CLKIN_RST;
            clk_s2_r <= PLLCS_CLKIN_RST;
        end else begin
            cfg_s1_r <= cfg_pin;
            cfg_s2_r <= cfg_s1_r;
            clk_s1_r <= clk_pin;
            clk_s2_r <= clk_s1_r;
        end
    end

    // ----------------------------------------
    // Oscillator source
    // ----------------------------------------
    logic [2:0] int_cnt_r, int_cnt_nxt;
    logic       int_clk_r, int_clk_nxt;
    logic       ext_prev_r, ext_prev_nxt;
    logic       ext_half_r, ext_half_nxt;
    logic       master_r, master_nxt;
    logic [2:0] int_half;

    always_comb begin
        int_half     = (cfg_s2_r.osc_code == PLLCS_OSC_INT_1244) ? PLLCS_INT_HALF_1244 : PLLCS_INT_HALF_622;
        int_cnt_nxt  = 3'(int_cnt_r + 3'h1);
        int_clk_nxt  = int_clk_r;
        if (int_cnt_nxt >= int_half) begin
            int_cnt_nxt = 3'h0;
            int_clk_nxt = !int_clk_r;
        end
        ext_prev_nxt = clk_s2_r.ext;
        ext_half_nxt = (clk_s2_r.ext && !ext_prev_r) ? !ext_half_r : ext_half_r;
        case (cfg_s2_r.osc_code)
            PLLCS_OSC_EXT_DIV2: master_nxt = ext_half_r;
            PLLCS_OSC_INT_622:  master_nxt = int_clk_r;
            PLLCS_OSC_INT_1244: master_nxt = int_clk_r;
            default:            master_nxt = clk_s2_r.ext;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_cnt_r  <= 3'h0;
            int_clk_r  <= 1'b0;
            ext_prev_r <= 1'b0;
            ext_half_r <= 1'b0;
            master_r   <= 1'b0;
        end else begin
            int_cnt_r  <= int_cnt_nxt;
            int_clk_r  <= int_clk_nxt;
            ext_prev_r <= ext_prev_nxt;
            ext_half_r <= ext_half_nxt;
            master_r   <= master_nxt;
        end
    end

    // ----------------------------------------
    // Dividers
    // ----------------------------------------
    logic       fb;
    logic [5:0] clk_vec;

    pllcs_fb_div u_fb_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .master  (master_r),
        .code    (cfg_s2_r.pre_code),
        .fb      (fb)
    );

    pllcs_out_div u_out_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .master  (master_r),
        .en      (cfg_s2_r.out_en),
        .clk_out (clk_vec)
    );

    assign clk_out_master_a  = clk_vec[5];
    assign clk_out_master_b  = clk_vec[4];
    assign clk_out_half      = clk_vec[3];
    assign clk_out_quarter   = clk_vec[2];
    assign clk_out_eighth    = clk_vec[1];
    assign clk_out_sixteenth = clk_vec[0];

    // ----------------------------------------
    // Detector, charge pump, lock filter
    // ----------------------------------------
    logic       ref_r, ref_nxt;
    logic       ref_prev_r, ref_prev_nxt;
    logic       fb_prev_r, fb_prev_nxt;
    logic       up_r, up_nxt;
    logic       dn_r, dn_nxt;
    logic       raw_r, raw_nxt;
    logic [7:0] lk_cnt_r, lk_cnt_nxt;
    logic       locked_r, locked_nxt;
    logic       lock_n_r, lock_n_nxt;

    always_comb begin
        case (cfg_s2_r.ref_code)
            PLLCS_REF_IN1: ref_nxt = clk_s2_r.ref1;
            PLLCS_REF_IN2: ref_nxt = clk_s2_r.ref2;
            PLLCS_REF_IN3: ref_nxt = clk_s2_r.ref3;
            default:       ref_nxt = 1'b0;
        endcase
        ref_prev_nxt = ref_r;
        fb_prev_nxt  = fb;
        // Edge-driven detector: a late feedback edge asks for speed
        up_nxt = up_r || (ref_r && !ref_prev_r);
        dn_nxt = dn_r || (fb && !fb_prev_r);
        if (up_nxt && dn_nxt) begin
            up_nxt = 1'b0;
            dn_nxt = 1'b0;
        end
        raw_nxt = ref_r ^ fb;
        // Integrator stands in for the external filter capacitor
        if (raw_r) begin
            lk_cnt_nxt = (lk_cnt_r == PLLCS_LOCK_MAX) ? lk_cnt_r : 8'(lk_cnt_r + 8'h01);
        end else begin
            lk_cnt_nxt = (lk_cnt_r == 8'h00) ? lk_cnt_r : 8'(lk_cnt_r - 8'h01);
        end
        if (lk_cnt_r <= PLLCS_LOCK_ON) begin
            locked_nxt = 1'b1;
        end else if (lk_cnt_r >= PLLCS_LOCK_OFF) begin
            locked_nxt = 1'b0;
        end else begin
            locked_nxt = locked_r;
        end
        lock_n_nxt = !locked_nxt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_r      <= 1'b0;
            ref_prev_r <= 1'b0;
            fb_prev_r  <= 1'b0;
            up_r       <= 1'b0;
            dn_r       <= 1'b0;
            raw_r      <= 1'b0;
            lk_cnt_r   <= PLLCS_LOCK_MAX;
            locked_r   <= 1'b0;
            lock_n_r   <= 1'b1;
        end else begin
            ref_r      <= ref_nxt;
            ref_prev_r <= ref_prev_nxt;
            fb_prev_r  <= fb_prev_nxt;
            up_r       <= up_nxt;
            dn_r       <= dn_nxt;
            raw_r      <= raw_nxt;
            lk_cnt_r   <= lk_cnt_nxt;
            locked_r   <= locked_nxt;
            lock_n_r   <= lock_n_nxt;
        end
    end

    assign cp_sink         = up_r;
    assign cp_source       = dn_r;
    assign lock_detect_raw = raw_r;
    assign lock_flag_n     = lock_n_r;

    // ----------------------------------------
    // AHB-Lite registers and interrupt
    // ----------------------------------------
    pllcs_cfg_type         cfg_prev_r;
    logic [PLLCS_EV_W-1:0] status_r, status_nxt;
    logic [PLLCS_EV_W-1:0] mask_r, mask_nxt;
    logic [PLLCS_EV_W-1:0] events;
    logic                  irq_r, irq_nxt;
    logic                  wr_pend_r, wr_pend_nxt;
    logic [31:0]           wr_addr_r, wr_addr_nxt;
    logic [31:0]           rdata_r, rdata_nxt;
    logic                  rd_acc, wr_acc, rd_status;

    function automatic logic [31:0] reg_read(input logic [31:0] addr);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (addr == PLLCS_OFF_STATUS) begin
            v[PLLCS_EV_W-1:0] = status_r;
        end else if (addr == PLLCS_OFF_MASK) begin
            v[PLLCS_EV_W-1:0] = mask_r;
        end else if (addr == PLLCS_OFF_STATE) begin
            v[12:0]               = cfg_s2_r;
            v[PLLCS_STATE_LOCK]   = locked_r;
            v[PLLCS_STATE_SINK]   = up_r;
            v[PLLCS_STATE_SOURCE] = dn_r;
        end
        return v;
    endfunction : reg_read

    always_comb begin
        rd_acc      = hsel && hready && htrans[1] && !hwrite;
        wr_acc      = hsel && hready && htrans[1] && hwrite;
        rd_status   = rd_acc && (haddr == PLLCS_OFF_STATUS);
        events                     = '0;
        events[PLLCS_EV_LOCK_GAIN] = locked_nxt && !locked_r;
        events[PLLCS_EV_LOCK_LOSS] = !locked_nxt && locked_r;
        events[PLLCS_EV_CFG_CHG]   = cfg_s2_r != cfg_prev_r;
        // New events survive a clearing read in the same cycle
        status_nxt  = (rd_status ? '0 : status_r) | events;
        wr_pend_nxt = wr_acc;
        wr_addr_nxt = wr_acc ? haddr : wr_addr_r;
        mask_nxt    = (wr_pend_r && wr_addr_r == PLLCS_OFF_MASK) ? hwdata[PLLCS_EV_W-1:0] : mask_r;
        rdata_nxt   = rd_acc ? reg_read(haddr) : 32'h0000_0000;
        irq_nxt     = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_prev_r <= PLLCS_CFG_RST;
            status_r   <= PLLCS_STATUS_RST;
            mask_r     <= PLLCS_MASK_RST;
            irq_r      <= 1'b0;
            wr_pend_r  <= 1'b0;
            wr_addr_r  <= 32'h0000_0000;
            rdata_r    <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            cfg_prev_r <= cfg_s2_r;
            status_r   <= status_nxt;
            mask_r     <= mask_nxt;
            irq_r      <= irq_nxt;
            wr_pend_r  <= wr_pend_nxt;
            wr_addr_r  <= wr_addr_nxt;
            rdata_r    <= rdata_nxt;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
    end

    assign hrdata = rdata_r;
    assign irq    = irq_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_ref_rise;
        ref_r && !ref_prev_r;
    endsequence

    sequence s_fb_quiet;
        !(fb && !fb_prev_r) && !dn_r;
    endsequence

    a_ref_none_off: assert property (
        cfg_s2_r.ref_code == PLLCS_REF_NONE |=> !ref_r) else $error("reference reached detector");
    a_ref_route_one: assert property (
        cfg_s2_r.ref_code == PLLCS_REF_IN1 |=> ref_r == $past(clk_s2_r.ref1)) else $error("input one misrouted");
    a_osc_ext_direct: assert property (
        cfg_s2_r.osc_code == PLLCS_OSC_EXT_DIV1 |=> master_r == $past(clk_s2_r.ext)) else $error("ext path wrong");
    a_osc_int_rate: assert property (
        cfg_s2_r.osc_code == PLLCS_OSC_INT_1244 [*3] |-> int_clk_r != $past(int_clk_r)) else $error("int rate wrong");
    a_lock_flag_level: assert property (
        (lk_cnt_r <= PLLCS_LOCK_ON) |=> !lock_flag_n) else $error("lock flag not low in lock");
    a_unlock_flag: assert property (
        (lk_cnt_r >= PLLCS_LOCK_OFF) |=> lock_flag_n) else $error("lock flag not high out of lock");
    a_raw_xor_out: assert property (
        1'b1 |=> lock_detect_raw == ($past(ref_r) ^ $past(fb))) else $error("raw lock not xor");
    a_pump_sink_up: assert property (
        s_ref_rise and s_fb_quiet |=> cp_sink && !cp_source) else $error("pump did not sink");
    a_status_rd_clear: assert property (
        rd_status && events == '0 |=> status_r == '0) else $error("status not cleared by read");
    a_irq_follows: assert property (
        irq == |(status_r & mask_r)) else $error("irq disagrees with status and mask");

endmodule : pllcs_top
`default_nettype wire

// ---- sim/pllcs_board.sv ----
`timescale 1ns/1ps
`default_nettype none
module pllcs_board import pllcs_pkg::*; (
    // Clock
    input  wire logic           hclk,
    // Wanted setting, and the pins it drives
    input  wire pllcs_cfg_type  cfg,
    output var pllcs_clkin_type clks,
    output var pllcs_cfg_type   pins
);
    int cnt = 0;
    // Distinct slow clocks, so a routing slip shows up as a wrong period
    always @(posedge hclk) begin
        cnt       <= cnt + 1;
        pins      <= cfg;
        clks.ref1 <= (cnt % 10) < 5;
        clks.ref2 <= (cnt % 12) < 6;
        clks.ref3 <= (cnt % 14) < 7;
        clks.ext  <= (cnt % 8) < 4;
    end
endmodule : pllcs_board
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb import pllcs_pkg::*;;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, cp_sink, cp_source;
    logic [31:0]     haddr, hwdata, hrdata, rd;
    logic [1:0]      htrans;
    logic            ref_clock_in_1, ref_clock_in_2, ref_clock_in_3, ext_osc_in;
    logic            ref_select_hi, ref_select_lo, prescale_select_b2, prescale_select_b1, prescale_select_b0;
    logic            osc_source_select_hi, osc_source_select_lo, out_enable_master_a, out_enable_master_b;
    logic            out_enable_div2, out_enable_div4, out_enable_div8, out_enable_div16;
    logic            clk_out_master_a, clk_out_master_b, clk_out_half, clk_out_quarter, clk_out_eighth;
    logic            clk_out_sixteenth, lock_flag_n, lock_detect_raw;
    logic [6:0]      obs;
    logic [31:0]     osc_p [4] = '{32'h10, 32'h4, 32'h2, 32'h8};
    pllcs_cfg_type   cfg, pins, c;
    pllcs_clkin_type clks;
    int              bad_count = 0;
    int              checks = 0;

    assign {ref_clock_in_1, ref_clock_in_2, ref_clock_in_3, ext_osc_in} = clks;
    assign {ref_select_hi, ref_select_lo, prescale_select_b2, prescale_select_b1, prescale_select_b0,
            osc_source_select_hi, osc_source_select_lo, out_enable_master_a, out_enable_master_b,
            out_enable_div2, out_enable_div4, out_enable_div8, out_enable_div16} = pins;
    assign obs = {lock_detect_raw, clk_out_sixteenth, clk_out_eighth, clk_out_quarter, clk_out_half,
                  clk_out_master_b, clk_out_master_a};

    pllcs_board pllcs_board_inst (.hclk, .cfg, .clks, .pins);
    pllcs_top pllcs_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ref_clock_in_1, .ref_clock_in_2, .ref_clock_in_3,
        .ext_osc_in, .ref_select_hi, .ref_select_lo, .prescale_select_b2, .prescale_select_b1,
        .prescale_select_b0, .osc_source_select_hi, .osc_source_select_lo, .out_enable_master_a,
        .out_enable_master_b, .out_enable_div2, .out_enable_div4, .out_enable_div8, .out_enable_div16,
        .clk_out_master_a, .clk_out_master_b, .clk_out_half, .clk_out_quarter, .clk_out_eighth,
        .clk_out_sixteenth, .lock_flag_n, .lock_detect_raw, .cp_sink, .cp_source, .irq);

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t ns: got %h, want %h", $time, seen, exp);
        end
    endtask : check

    // Read before the edge's own updates land, so the values are those the edge saw
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (hreadyout !== 1'b1) bad_count++;
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask : bus

    task automatic setup(input pllcs_cfg_type v);
        @(posedge hclk);
        cfg <= v;
        repeat (40) @(posedge hclk);
    endtask : setup

    // Cycles between two rises of one observed pin; zero if it never rises
    task automatic period(input int i, input logic [31:0] exp);
        logic        prev;
        int          st, n;
        logic [31:0] p;
        p = 32'h0;
        st = 0;
        n = 0;
        prev = obs[i];
        while (st < 2 && n < 1200) begin
            @(negedge hclk);
            n++;
            if (st == 1) p++;
            if (obs[i] === 1'b1 && prev === 1'b0) st++;
            prev = obs[i];
        end
        check(p, exp);
    endtask : period

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        cfg = PLLCS_CFG_RST;
        c = PLLCS_CFG_RST;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        check(lock_flag_n, 1'b1);
        bus(1'b0, PLLCS_OFF_STATE, 32'h0);
        check(rd & 32'h1FFF, 32'h1FFF);
        check(hresp, 1'b0);
        bus(1'b0, 32'h0000_000C, 32'h0);
        check(rd, 32'h0);
        $display("test defaults done");
        for (int i = 0; i < 6; i++) begin
            c.out_en = 6'h20 >> i;
            setup(c);
            period(i, 32'h8 << (i < 2 ? 0 : i - 1));
            check(obs[5:0] & ~(6'h1 << i), 6'h00);
        end
        $display("test outputs done");
        c.out_en = 6'h3F;
        for (int k = 0; k < 4; k++) begin
            c.osc_code = k[1:0];
            setup(c);
            period(0, osc_p[k]);
        end
        $display("test oscillator done");
        for (int k = 0; k < 8; k++) begin
            c.pre_code = k[2:0];
            setup(c);
            period(6, k < 7 ? 32'h8 << k : 32'h0);
        end
        check(cp_source, 1'b1);
        check(cp_sink, 1'b0);
        repeat (300) @(posedge hclk);
        check(lock_flag_n, 1'b0);
        bus(1'b0, PLLCS_OFF_STATE, 32'h0);
        check(rd[PLLCS_STATE_LOCK], 1'b1);
        for (int k = 0; k < 3; k++) begin
            c.ref_code = k[1:0];
            setup(c);
            period(6, 32'hA + 32'h2 * k);
        end
        check(cp_sink, 1'b1);
        check(cp_source, 1'b0);
        $display("test loop done");
        bus(1'b1, PLLCS_OFF_MASK, 32'h4);
        bus(1'b0, PLLCS_OFF_MASK, 32'h0);
        check(rd, 32'h4);
        bus(1'b0, PLLCS_OFF_STATUS, 32'h0);
        check(rd[2:0], 3'h7);
        check(irq, 1'b0);
        c.out_en = 6'h15;
        setup(c);
        check(irq, 1'b1);
        bus(1'b0, PLLCS_OFF_STATUS, 32'h0);
        check(rd[2], 1'b1);
        bus(1'b0, PLLCS_OFF_STATUS, 32'h0);
        check(rd[2], 1'b0);
        check(irq, 1'b0);
        bus(1'b1, PLLCS_OFF_MASK, 32'h0);
        c.out_en = 6'h3F;
        setup(c);
        check(irq, 1'b0);
        $display("test interrupt done");
        final_report();
    end

    initial begin
        repeat (60000) @(posedge hclk);
        bad_count++;
        final_report();
    end
endmodule : tb
`default_nettype wire
